// ===== include/second_interrupt_pin_router_pkg.sv
// shared constants, types and helpers for the second-pin event router
package second_interrupt_pin_router_pkg;

  // data and register widths
  localparam int DATA_W   = 32;
  localparam int REG_W    = 8;
  localparam int EMB_W    = 4;
  localparam int MACH_W   = 8;
  localparam int IRQ_W    = 6;
  localparam int IDX_LSB  = 2;
  localparam int IDX_MSB  = 9;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_EMB_ROUTE   = 8'h0E;
  localparam logic [7:0] IDX_MACH_ROUTE_L = 8'h0F;
  localparam logic [7:0] IDX_MACH_ROUTE_H = 8'h10;
  localparam logic [7:0] IDX_EMB_STATUS  = 8'h12;
  localparam logic [7:0] IDX_MACH_STAT_L = 8'h13;
  localparam logic [7:0] IDX_MACH_STAT_H = 8'h14;
  localparam logic [7:0] IDX_LATCH_CFG   = 8'h17;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h21;
  localparam logic [7:0] IDX_ROUTING_CFG = 8'h5F;

  // field positions inside the 8-bit registers
  localparam int BIT_LONG    = 7;
  localparam int BIT_SIGMOT  = 5;
  localparam int BIT_TILT    = 4;
  localparam int BIT_STEP    = 3;
  localparam int BIT_LATCH   = 7;
  localparam int BIT_MASTER  = 1;

  // reset values
  localparam logic [EMB_W-1:0]  EMB_ROUTE_RST  = 4'h0;
  localparam logic [MACH_W-1:0] MACH_ROUTE_RST = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST   = 6'h00;
  localparam logic              LATCH_RST      = 1'b0;
  localparam logic              MASTER_RST     = 1'b0;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // embedded events, also the nibble order of the internal status
  typedef struct packed {
    logic long_timeout;
    logic significant_motion;
    logic tilt;
    logic step;
  } embedded_events_t;

  // spread a status/routing nibble over its byte positions
  function automatic logic [REG_W-1:0] emb_to_byte(input logic [EMB_W-1:0] n);
    logic [REG_W-1:0] b;
    b = 8'h00;
    b[BIT_LONG]   = n[3];
    b[BIT_SIGMOT] = n[2];
    b[BIT_TILT]   = n[1];
    b[BIT_STEP]   = n[0];
    return b;
  endfunction : emb_to_byte

  // gather the defined bits of a byte, dropping reserved positions
  function automatic logic [EMB_W-1:0] byte_to_emb(input logic [REG_W-1:0] b);
    return {b[BIT_LONG], b[BIT_SIGMOT], b[BIT_TILT], b[BIT_STEP]};
  endfunction : byte_to_emb

endpackage : second_interrupt_pin_router_pkg

// ===== hdl/event_status_unit.sv
// status bits for a group of events, latched or following the events
`timescale 1ns/1ps

module event_status_unit #(
  parameter int W = 8
) (
  input  wire logic         aclk,        // system clock
  input  wire logic         aresetn,     // sync reset, active low
  input  wire logic [W-1:0] event_in,    // event levels or pulses
  input  wire logic         latch_mode,  // 1 holds bits until read
  input  wire logic         read_clear,  // read of the status register
  output logic      [W-1:0] status_ff    // detected state
);

  logic [W-1:0] nxt_status;

  initial begin
    if (W < 1) $error("event_status_unit: width must be at least one");
  end

  // latched: a new event wins over the clear of the same cycle
  assign nxt_status = latch_mode ? (event_in | (status_ff & ~{W{read_clear}}))
                                 : event_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) status_ff <= '0;
    else          status_ff <= nxt_status;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  latched_hold_a: assert property (
    (latch_mode && !read_clear) |=> ((status_ff & $past(status_ff)) == $past(status_ff)))
    else $error("latched status bit dropped without a read");

  unlatched_follow_a: assert property (
    !latch_mode |=> (status_ff == $past(event_in)))
    else $error("unlatched status does not follow its event");

  set_wins_a: assert property (
    (latch_mode && read_clear) |=> ((status_ff & $past(event_in)) == $past(event_in)))
    else $error("event lost against a read clear");

endmodule : event_status_unit

// ===== hdl/embedded_event_second_interrupt_pin_router.sv
// second interrupt pin router for embedded events, with AXI4-Lite registers
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// What this block does
// - pin is OR of all routed events
// - long-timeout routing bit, reset zero, forwards event
// - significant-motion routing bit, reset zero, forwards event
// - tilt routing bit, reset zero, forwards event
// - step routing bit, reset zero, forwards event
// - master enable gates every pin routing bit
// - machines one to eight routing, reset zero
// - machines nine to sixteen routing, reset zero
// - status top bit shows long timeout
// - bit five significant motion; others read zero
// - status bit four shows tilt
// - status bit three shows step
// - machines one to eight status register
// - machines nine to sixteen status register
// - latch mode bit, default unlatched
module embedded_event_second_interrupt_pin_router #(
  parameter int ADDR_W = 12
) (
  input  wire logic                            aclk,                 // system clock
  input  wire logic                            aresetn,              // sync reset, low
  input  wire logic [ADDR_W-1:0]               awaddr,               // write address
  input  wire logic                            awvalid,              // write address valid
  output logic                                 awready,              // write address ready
  input  wire logic [second_interrupt_pin_router_pkg::DATA_W-1:0]   wdata,           // write data
  input  wire logic [second_interrupt_pin_router_pkg::DATA_W/8-1:0] wstrb,           // write strobes
  input  wire logic                            wvalid,               // write data valid
  output logic                                 wready,               // write data ready
  output logic [1:0]                           bresp,                // write response
  output logic                                 bvalid,               // write response valid
  input  wire logic                            bready,               // write response ready
  input  wire logic [ADDR_W-1:0]               araddr,               // read address
  input  wire logic                            arvalid,              // read address valid
  output logic                                 arready,              // read address ready
  output logic [second_interrupt_pin_router_pkg::DATA_W-1:0]   rdata,                // read data
  output logic [1:0]                           rresp,                // read response
  output logic                                 rvalid,               // read data valid
  input  wire logic                            rready,               // read data ready
  input  wire second_interrupt_pin_router_pkg::embedded_events_t embedded_events,    // embedded events
  input  wire logic [2*second_interrupt_pin_router_pkg::MACH_W-1:0] machine_events,  // machine 1 in bit 0
  output logic                                 second_interrupt_pin, // routed pin
  output logic                                 irq                   // summary interrupt
);

  initial begin
    if (ADDR_W < second_interrupt_pin_router_pkg::IDX_MSB + 1)
      $error("embedded_event_second_interrupt_pin_router: ADDR_W too small for the map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // address helpers

  // word index of a byte address; out-of-window addresses give no hit
  function automatic logic [7:0] addr_index(input logic [ADDR_W-1:0] a);
    return a[second_interrupt_pin_router_pkg::IDX_MSB:second_interrupt_pin_router_pkg::IDX_LSB];
  endfunction : addr_index

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    logic       high_zero;
    i         = a[second_interrupt_pin_router_pkg::IDX_MSB:second_interrupt_pin_router_pkg::IDX_LSB];
    high_zero = ((a >> (second_interrupt_pin_router_pkg::IDX_MSB + 1)) == '0);
    return high_zero && (i == second_interrupt_pin_router_pkg::IDX_EMB_ROUTE
                      || i == second_interrupt_pin_router_pkg::IDX_MACH_ROUTE_L
                      || i == second_interrupt_pin_router_pkg::IDX_MACH_ROUTE_H
                      || i == second_interrupt_pin_router_pkg::IDX_EMB_STATUS
                      || i == second_interrupt_pin_router_pkg::IDX_MACH_STAT_L
                      || i == second_interrupt_pin_router_pkg::IDX_MACH_STAT_H
                      || i == second_interrupt_pin_router_pkg::IDX_LATCH_CFG
                      || i == second_interrupt_pin_router_pkg::IDX_IRQ_STATUS
                      || i == second_interrupt_pin_router_pkg::IDX_IRQ_MASK
                      || i == second_interrupt_pin_router_pkg::IDX_ROUTING_CFG);
  endfunction : addr_mapped

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                                  awready_ff, wready_ff, bvalid_ff;
  logic [1:0]                            bresp_ff, rresp_ff;
  logic                                  arready_ff, rvalid_ff;
  logic [second_interrupt_pin_router_pkg::DATA_W-1:0]    rdata_ff;
  logic                                  aw_got_ff, w_got_ff;
  logic [ADDR_W-1:0]                     aw_addr_ff;
  logic [second_interrupt_pin_router_pkg::REG_W-1:0]     w_data_ff;
  logic                                  w_lane0_ff;
  logic [second_interrupt_pin_router_pkg::EMB_W-1:0]     emb_route_ff;
  logic [second_interrupt_pin_router_pkg::MACH_W-1:0]    mach_route_l_ff, mach_route_h_ff;
  logic                                  latch_mode_ff, master_en_ff;
  logic [second_interrupt_pin_router_pkg::IRQ_W-1:0]     irq_mask_ff;
  logic                                  pin_ff, irq_ff;
  logic [second_interrupt_pin_router_pkg::EMB_W-1:0]     emb_status;
  logic [second_interrupt_pin_router_pkg::MACH_W-1:0]    mach_status_l, mach_status_h;
  logic [second_interrupt_pin_router_pkg::IRQ_W-1:0]     irq_status;

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  // address and data are taken in either order and held until the write
  wire aw_take  = awvalid && awready_ff;
  wire w_take   = wvalid && wready_ff;
  wire aw_have  = aw_got_ff || aw_take;
  wire w_have   = w_got_ff || w_take;
  wire wr_fire  = aw_got_ff && w_got_ff && !bvalid_ff;
  wire b_done   = bvalid_ff && bready;
  wire nxt_aw_got  = aw_have && !wr_fire;
  wire nxt_w_got   = w_have && !wr_fire;
  wire nxt_bvalid  = wr_fire || (bvalid_ff && !bready);
  // each ready only while its own channel holds nothing and no response waits, so at most one write is in flight
  wire nxt_awready = !nxt_aw_got && !nxt_bvalid && !aw_got_ff;
  wire nxt_wready  = !nxt_w_got && !nxt_bvalid && !w_got_ff;

  wire [7:0] wr_idx   = addr_index(aw_addr_ff);
  wire       wr_map   = addr_mapped(aw_addr_ff);
  // only lane 0 carries register bits; other lanes are accepted and dropped
  wire       wr_en    = wr_fire && wr_map && w_lane0_ff;
  wire wr_emb_route   = wr_en && (wr_idx == second_interrupt_pin_router_pkg::IDX_EMB_ROUTE);
  wire wr_route_l     = wr_en && (wr_idx == second_interrupt_pin_router_pkg::IDX_MACH_ROUTE_L);
  wire wr_route_h     = wr_en && (wr_idx == second_interrupt_pin_router_pkg::IDX_MACH_ROUTE_H);
  wire wr_latch       = wr_en && (wr_idx == second_interrupt_pin_router_pkg::IDX_LATCH_CFG);
  wire wr_cfg         = wr_en && (wr_idx == second_interrupt_pin_router_pkg::IDX_ROUTING_CFG);
  wire wr_mask        = wr_en && (wr_idx == second_interrupt_pin_router_pkg::IDX_IRQ_MASK);
  wire [1:0] nxt_bresp = wr_map ? second_interrupt_pin_router_pkg::RESP_OKAY
                                : second_interrupt_pin_router_pkg::RESP_SLVERR;

  // write handshake state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      bvalid_ff  <= nxt_bvalid;
    end
  end

  // write payload holding, no reset needed for data
  always_ff @(posedge aclk) begin
    if (aw_take) aw_addr_ff <= awaddr;
    if (w_take) begin
      w_data_ff  <= wdata[second_interrupt_pin_router_pkg::REG_W-1:0];
      w_lane0_ff <= wstrb[0];
    end
    if (wr_fire) bresp_ff <= nxt_bresp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // reserved routing positions are not stored, the host keeps them zero
  wire [second_interrupt_pin_router_pkg::EMB_W-1:0] nxt_emb_route =
    wr_emb_route ? second_interrupt_pin_router_pkg::byte_to_emb(w_data_ff) : emb_route_ff;

  // routing, latch mode and master enable, all zero after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emb_route_ff    <= second_interrupt_pin_router_pkg::EMB_ROUTE_RST;
      mach_route_l_ff <= second_interrupt_pin_router_pkg::MACH_ROUTE_RST;
      mach_route_h_ff <= second_interrupt_pin_router_pkg::MACH_ROUTE_RST;
      latch_mode_ff   <= second_interrupt_pin_router_pkg::LATCH_RST;
      master_en_ff    <= second_interrupt_pin_router_pkg::MASTER_RST;
      irq_mask_ff     <= second_interrupt_pin_router_pkg::IRQ_MASK_RST;
    end else begin
      emb_route_ff <= nxt_emb_route;
      if (wr_route_l) mach_route_l_ff <= w_data_ff;
      if (wr_route_h) mach_route_h_ff <= w_data_ff;
      if (wr_latch)   latch_mode_ff <= w_data_ff[second_interrupt_pin_router_pkg::BIT_LATCH];
      if (wr_cfg)     master_en_ff  <= w_data_ff[second_interrupt_pin_router_pkg::BIT_MASTER];
      if (wr_mask)    irq_mask_ff   <= w_data_ff[second_interrupt_pin_router_pkg::IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  wire       ar_take = arvalid && arready_ff;
  wire       r_done  = rvalid_ff && rready;
  wire [7:0] rd_idx  = addr_index(araddr);
  wire       rd_map  = addr_mapped(araddr);
  wire nxt_rvalid    = ar_take || (rvalid_ff && !rready);
  wire nxt_arready   = !nxt_rvalid && !ar_take;

  // reading a status register clears what it has shown while latched; unlatched status keeps following its events
  wire clr_emb    = ar_take && rd_map && (rd_idx == second_interrupt_pin_router_pkg::IDX_EMB_STATUS);
  wire clr_mach_l = ar_take && rd_map && (rd_idx == second_interrupt_pin_router_pkg::IDX_MACH_STAT_L);
  wire clr_mach_h = ar_take && rd_map && (rd_idx == second_interrupt_pin_router_pkg::IDX_MACH_STAT_H);
  wire clr_irq    = ar_take && rd_map && (rd_idx == second_interrupt_pin_router_pkg::IDX_IRQ_STATUS);

  // read data selection, unused bits and reserved positions read zero
  wire [second_interrupt_pin_router_pkg::REG_W-1:0] rd_byte =
    !rd_map ? 8'h00 :
    (rd_idx == second_interrupt_pin_router_pkg::IDX_EMB_ROUTE)    ?
      second_interrupt_pin_router_pkg::emb_to_byte(emb_route_ff) :
    (rd_idx == second_interrupt_pin_router_pkg::IDX_MACH_ROUTE_L) ? mach_route_l_ff :
    (rd_idx == second_interrupt_pin_router_pkg::IDX_MACH_ROUTE_H) ? mach_route_h_ff :
    (rd_idx == second_interrupt_pin_router_pkg::IDX_EMB_STATUS)   ?
      second_interrupt_pin_router_pkg::emb_to_byte(emb_status) :
    (rd_idx == second_interrupt_pin_router_pkg::IDX_MACH_STAT_L)  ? mach_status_l :
    (rd_idx == second_interrupt_pin_router_pkg::IDX_MACH_STAT_H)  ? mach_status_h :
    (rd_idx == second_interrupt_pin_router_pkg::IDX_LATCH_CFG)    ?
      (8'({latch_mode_ff}) << second_interrupt_pin_router_pkg::BIT_LATCH) :
    (rd_idx == second_interrupt_pin_router_pkg::IDX_IRQ_STATUS)   ? 8'(irq_status) :
    (rd_idx == second_interrupt_pin_router_pkg::IDX_IRQ_MASK)     ? 8'(irq_mask_ff) :
    (8'({master_en_ff}) << second_interrupt_pin_router_pkg::BIT_MASTER);
  wire [1:0] nxt_rresp = rd_map ? second_interrupt_pin_router_pkg::RESP_OKAY
                                : second_interrupt_pin_router_pkg::RESP_SLVERR;

  // read handshake state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= second_interrupt_pin_router_pkg::RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= {{(second_interrupt_pin_router_pkg::DATA_W - second_interrupt_pin_router_pkg::REG_W){1'b0}}, rd_byte};
        rresp_ff <= nxt_rresp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status

  event_status_unit #(.W(second_interrupt_pin_router_pkg::EMB_W)) emb_stat_u (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .event_in   (embedded_events),
    .latch_mode (latch_mode_ff),
    .read_clear (clr_emb),
    .status_ff  (emb_status)
  );

  event_status_unit #(.W(second_interrupt_pin_router_pkg::MACH_W)) mach_l_stat_u (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .event_in   (machine_events[second_interrupt_pin_router_pkg::MACH_W-1:0]),
    .latch_mode (latch_mode_ff),
    .read_clear (clr_mach_l),
    .status_ff  (mach_status_l)
  );

  event_status_unit #(.W(second_interrupt_pin_router_pkg::MACH_W)) mach_h_stat_u (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .event_in   (machine_events[2*second_interrupt_pin_router_pkg::MACH_W-1:second_interrupt_pin_router_pkg::MACH_W]),
    .latch_mode (latch_mode_ff),
    .read_clear (clr_mach_h),
    .status_ff  (mach_status_h)
  );

  // summary interrupt sources are always sticky until read
  wire [second_interrupt_pin_router_pkg::IRQ_W-1:0] irq_events =
    {|machine_events[2*second_interrupt_pin_router_pkg::MACH_W-1:second_interrupt_pin_router_pkg::MACH_W],
     |machine_events[second_interrupt_pin_router_pkg::MACH_W-1:0], embedded_events};

  event_status_unit #(.W(second_interrupt_pin_router_pkg::IRQ_W)) irq_stat_u (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .event_in   (irq_events),
    .latch_mode (1'b1),
    .read_clear (clr_irq),
    .status_ff  (irq_status)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin and interrupt outputs

  // each contribution is detected state AND route; one flop of delay on the pin
  wire [second_interrupt_pin_router_pkg::EMB_W-1:0]  emb_contrib   = emb_status & emb_route_ff;
  wire [second_interrupt_pin_router_pkg::MACH_W-1:0] mach_contrib_l = mach_status_l & mach_route_l_ff;
  wire [second_interrupt_pin_router_pkg::MACH_W-1:0] mach_contrib_h = mach_status_h & mach_route_h_ff;
  wire pin_cause = |emb_contrib || |mach_contrib_l || |mach_contrib_h;
  wire nxt_pin   = master_en_ff && pin_cause;
  wire nxt_irq   = |(irq_status & irq_mask_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
      irq_ff <= nxt_irq;
    end
  end

  assign awready              = awready_ff;
  assign wready               = wready_ff;
  assign bvalid               = bvalid_ff;
  assign bresp                = bresp_ff;
  assign arready              = arready_ff;
  assign rvalid               = rvalid_ff;
  assign rdata                = rdata_ff;
  assign rresp                = rresp_ff;
  assign second_interrupt_pin = pin_ff;
  assign irq                  = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence read_of(logic [7:0] idx);
    ar_take && rd_map && (rd_idx == idx);
  endsequence

  sequence data_back;
    rvalid_ff && (rresp_ff == second_interrupt_pin_router_pkg::RESP_OKAY);
  endsequence

  pin_or_a: assert property (
    (master_en_ff && (|mach_contrib_l || |mach_contrib_h || |emb_contrib))
      |=> second_interrupt_pin)
    else $error("routed event did not raise the pin");

  long_route_a: assert property (
    (master_en_ff && emb_status[3] && emb_route_ff[3]) |=> second_interrupt_pin)
    else $error("long timeout not forwarded");

  sigmot_route_a: assert property (
    (master_en_ff && emb_status[2] && emb_route_ff[2]) |=> second_interrupt_pin)
    else $error("significant motion not forwarded");

  tilt_route_a: assert property (
    (master_en_ff && emb_status[1] && emb_route_ff[1]) |=> second_interrupt_pin)
    else $error("tilt not forwarded");

  step_route_a: assert property (
    (master_en_ff && emb_status[0] && emb_route_ff[0]) |=> second_interrupt_pin)
    else $error("step not forwarded");

  master_gate_a: assert property (
    !master_en_ff |=> !second_interrupt_pin)
    else $error("pin high while master enable is off");

  blocked_pin_a: assert property (
    !pin_cause |=> !second_interrupt_pin)
    else $error("pin high with no routed event");

  mach_low_a: assert property (
    (master_en_ff && |(mach_status_l & mach_route_l_ff)) |=> second_interrupt_pin)
    else $error("machine 1-8 event not forwarded");

  mach_high_a: assert property (
    (master_en_ff && |(mach_status_h & mach_route_h_ff)) |=> second_interrupt_pin)
    else $error("machine 9-16 event not forwarded");

  emb_status_read_a: assert property (
    read_of(second_interrupt_pin_router_pkg::IDX_EMB_STATUS) |=> data_back
      ##0 (rdata_ff[second_interrupt_pin_router_pkg::BIT_LONG] == $past(emb_status[3])))
    else $error("long timeout status bit wrong");

  emb_reserved_a: assert property (
    read_of(second_interrupt_pin_router_pkg::IDX_EMB_STATUS) |=> data_back
      ##0 (rdata_ff[6] == 1'b0) && (rdata_ff[2:0] == 3'h0)
      && (rdata_ff[second_interrupt_pin_router_pkg::BIT_SIGMOT] == $past(emb_status[2])))
    else $error("embedded status layout wrong");

  tilt_step_read_a: assert property (
    read_of(second_interrupt_pin_router_pkg::IDX_EMB_STATUS) |=> data_back
      ##0 (rdata_ff[second_interrupt_pin_router_pkg::BIT_TILT] == $past(emb_status[1]))
      && (rdata_ff[second_interrupt_pin_router_pkg::BIT_STEP] == $past(emb_status[0])))
    else $error("tilt or step status bit wrong");

  mach_read_a: assert property (
    read_of(second_interrupt_pin_router_pkg::IDX_MACH_STAT_L) |=> data_back
      ##0 (rdata_ff[second_interrupt_pin_router_pkg::REG_W-1:0] == $past(mach_status_l)))
    else $error("machine status read wrong");

endmodule : embedded_event_second_interrupt_pin_router

// ===== verification/event_host_model.sv
// event source standing in for the sensing logic and host side
`timescale 1ns/1ps

module event_host_model (
  input  wire logic                             aclk,     // system clock
  input  wire logic [3:0]                       req_emb,  // wanted embedded levels
  input  wire logic [15:0]                      req_mach, // wanted machine levels
  output second_interrupt_pin_router_pkg::embedded_events_t     events,   // to the router
  output logic      [15:0]                      machines  // to the router
);
  // launched on the edge like real sensing logic, so no race with the router
  always_ff @(posedge aclk) begin
    events   <= req_emb;
    machines <= req_mach;
  end
endmodule : event_host_model

// ===== verification/embedded_event_second_interrupt_pin_router_tb_top.sv
// self-checking bench for the second-pin event router
`timescale 1ns/1ps
`define CHK(a,b,m) begin n_tests++; if ((a)!==(b)) begin n_mismatch++; $display("BAD %0t %s",$time,m); end end

module embedded_event_second_interrupt_pin_router_tb_top;
  localparam logic [1:0] OK = second_interrupt_pin_router_pkg::RESP_OKAY;
  localparam logic [1:0] ER = second_interrupt_pin_router_pkg::RESP_SLVERR;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, pin, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, req_emb;
  logic [1:0]  bresp, rresp;
  logic [15:0] req_mach, mach_ev;
  second_interrupt_pin_router_pkg::embedded_events_t emb_ev;
  int n_mismatch = 0;
  int n_tests = 0;
  embedded_event_second_interrupt_pin_router dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .embedded_events(emb_ev), .machine_events(mach_ev),
    .second_interrupt_pin(pin), .irq);
  event_host_model host_u (.aclk, .req_emb, .req_mach, .events(emb_ev), .machines(mach_ev));
  ////////////////////////////////////////////////////////////////
  // bus tasks: address and data released each at its own take
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e);
    logic a, w;
    a = 1'b1; w = 1'b1;
    awaddr <= {2'b00, i, 2'b00}; wdata <= {24'h000000, d};
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (a && awready) begin awvalid <= 1'b0; a = 1'b0; end
      if (w && wready) begin wvalid <= 1'b0; w = 1'b0; end
    end while (a || w);
    // bready stays up: dropping it here and raising it in the next call would
    // drive it twice in one time step
    do @(posedge aclk); while (bvalid !== 1'b1);
    `CHK(bresp, e, "write response")
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e);
    araddr <= {2'b00, i, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    // rready stays up for the same reason as bready
    do @(posedge aclk); while (rvalid !== 1'b1);
    `CHK(rdata, {24'h000000, d}, "read data")
    `CHK(rresp, e, "read response")
  endtask : rd
  // model, status and pin take one edge each; a read at an edge sees the
  // value from before it, so the fourth edge shows the settled result
  task automatic w3;
    repeat (4) @(posedge aclk);
  endtask : w3
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK(pin, 1'b0, "pin after reset")
    `CHK(irq, 1'b0, "irq after reset")
    rd(8'h0E, 8'h00, OK);
    rd(8'h0F, 8'h00, OK);
    rd(8'h10, 8'h00, OK);
    rd(8'h17, 8'h00, OK);
    rd(8'h5F, 8'h00, OK);
    rd(8'h21, 8'h00, OK);
  endtask : t_reset
  // each event alone, routed and unrouted, then machine bit order
  task automatic t_route;
    int pos[4] = '{3, 4, 5, 7};
    req_emb <= 4'hF;
    wr(8'h0E, 8'hB8, OK);
    w3;
    `CHK(pin, 1'b0, "pin without master")
    wr(8'h5F, 8'h02, OK);
    rd(8'h5F, 8'h02, OK);
    w3;
    `CHK(pin, 1'b1, "pin with master")
    for (int k = 0; k < 4; k++) begin
      req_emb <= 4'h1 << k;
      wr(8'h0E, 8'hB8 & ~(8'h01 << pos[k]), OK);
      w3;
      `CHK(pin, 1'b0, "event not routed")
      wr(8'h0E, 8'h01 << pos[k], OK);
      w3;
      `CHK(pin, 1'b1, "event routed")
    end
    req_emb <= 4'h0; req_mach <= 16'h8001;
    wr(8'h0F, 8'h80, OK);
    wr(8'h10, 8'h01, OK);
    w3;
    `CHK(pin, 1'b0, "wrong machines")
    req_mach <= 16'h0180;
    w3;
    `CHK(pin, 1'b1, "machines eight and nine")
    wr(8'h5F, 8'h00, OK);
    w3;
    `CHK(pin, 1'b0, "master off")
  endtask : t_route
  // events are quiet when latch mode turns on, so no older bit is held over
  task automatic t_status;
    req_emb <= 4'hF; req_mach <= 16'hA55A;
    w3;
    rd(8'h12, 8'hB8, OK);
    rd(8'h13, 8'h5A, OK);
    rd(8'h14, 8'hA5, OK);
    req_emb <= 4'h0; req_mach <= 16'h0000;
    wr(8'h17, 8'h80, OK);
    req_emb <= 4'h2;
    w3;
    req_emb <= 4'h0;
    w3;
    rd(8'h12, 8'h10, OK);
    rd(8'h12, 8'h00, OK);
    wr(8'h17, 8'h00, OK);
  endtask : t_status
  // sticky summary, mask, clear on read, unmapped place
  task automatic t_irq;
    rd(8'h20, 8'h3F, OK);
    rd(8'h30, 8'h00, ER);
    wr(8'h30, 8'h55, ER);
    wr(8'h21, 8'h01, OK);
    req_emb <= 4'h2;
    w3;
    `CHK(irq, 1'b0, "masked event")
    req_emb <= 4'h1;
    w3;
    req_emb <= 4'h0;
    `CHK(irq, 1'b1, "unmasked event")
    w3;
    rd(8'h20, 8'h03, OK);
    w3;
    `CHK(irq, 1'b0, "irq cleared")
    // a write without lane 0 is answered but leaves the mask alone
    wstrb <= 4'hE;
    wr(8'h21, 8'h3F, OK);
    wstrb <= 4'hF;
    rd(8'h21, 8'h01, OK);
  endtask : t_irq
  ////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // clock, reset and sequence
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    #200000;
    n_mismatch++;
    conclude;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h00000000; wstrb = 4'hF;
    req_emb = 4'h0; req_mach = 16'h0000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_route;
    t_status;
    t_irq;
    conclude;
  end
endmodule : embedded_event_second_interrupt_pin_router_tb_top
